// ### adc_fifo_partial_access.sv
// Serial readout of the result queue with partial reads and partial writes
`timescale 1ns/100ps
`default_nettype none
module adc_fifo_partial_access
  import adc_fifo_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe_n,
  // Conversion engine
  input wire logic convert_trigger_n,
  input wire logic scan_done,
  input wire logic result_valid,
  output logic result_ready,
  input wire logic [result_bits-1:0] result_code,
  input wire logic result_is_temp,
  output logic eoc_n,
  // Configuration and queue fault flag
  output logic [reg_bits-1:0] config_value,
  output logic config_strobe,
  output logic queue_fault
);
  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic [1:0] din_sync;
    logic [1:0] cnv_sync;
    logic cs_prev;
    logic sclk_prev;
    logic cnv_prev;
    logic [3:0] bit_pos;
    logic entry_active;
    logic resumed;
    logic [3:0] bits_this_frame;
    logic [reg_bits-1:0] wr_shift;
    logic [2:0] wr_pos;
    logic wr_done;
    logic [reg_bits-1:0] cfg;
    logic cfg_stb;
    logic dout;
    logic eoc_n;
    logic fault;
  } state_t;
  state_t s_q;
  state_t s_d;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic cnv_fall;
  logic pop;
  logic flush;
  logic q_valid;
  logic [entry_bits-1:0] q_data;
  logic [entry_bits-1:0] entry_word;
  logic tail_done;
  logic second_cut;
  logic first_cut;
  assign cs_fall = s_q.cs_prev && !s_q.cs_sync[1];
  assign cs_rise = !s_q.cs_prev && s_q.cs_sync[1];
  assign sclk_rise = !s_q.sclk_prev && s_q.sclk_sync[1];
  assign sclk_fall = s_q.sclk_prev && !s_q.sclk_sync[1];
  assign cnv_fall = s_q.cnv_prev && !s_q.cnv_sync[1];
  // Eight bits after a cut first byte finish the entry
  assign tail_done = s_q.resumed && s_q.bits_this_frame == pos_first_byte_end;
  // Release inside the second byte, or inside the bits after a cut first byte
  assign second_cut = (s_q.bit_pos > 4'(byte_bits)) ||
    (s_q.resumed && s_q.bits_this_frame != '0);
  assign first_cut = s_q.bit_pos < 4'(byte_bits);
  // Leading nibble zero, straight binary code below
  assign entry_word = {4'h0, result_code};
  always_comb
  begin
    s_d = s_q;
    pop = 1'b0;
    flush = 1'b0;
    s_d.cfg_stb = 1'b0;
    s_d.cs_sync = {s_q.cs_sync[0], cs_n};
    s_d.sclk_sync = {s_q.sclk_sync[0], sclk};
    s_d.din_sync = {s_q.din_sync[0], din};
    s_d.cnv_sync = {s_q.cnv_sync[0], convert_trigger_n};
    s_d.cs_prev = s_q.cs_sync[1];
    s_d.sclk_prev = s_q.sclk_sync[1];
    s_d.cnv_prev = s_q.cnv_sync[1];
    if (scan_done)
      s_d.eoc_n = 1'b0;
    else if (cs_fall || cnv_fall)
      s_d.eoc_n = 1'b1;
    // New frame: write shifter reloads from current config
    if (cs_fall)
    begin
      s_d.bits_this_frame = '0;
      s_d.wr_pos = '0;
      s_d.wr_done = 1'b0;
      s_d.wr_shift = s_q.cfg;
      if (s_q.eoc_n)
        s_d.fault = 1'b1;
    end
    if (!s_q.cs_sync[1])
    begin
      // Output bit at current position, MSB first
      if (sclk_fall || cs_fall)
        s_d.dout = q_valid ? q_data[pos_last - s_q.bit_pos] : 1'b0;
      if (sclk_rise)
      begin
        // First eight bits fill the config byte from the top
        if (!s_q.wr_done)
        begin
          s_d.wr_shift[3'(wpos_last - s_q.wr_pos)] = s_q.din_sync[1];
          s_d.wr_pos = s_q.wr_pos + 3'h1;
          if (s_q.wr_pos == wpos_last)
            s_d.wr_done = 1'b1;
        end
        if (q_valid)
        begin
          s_d.entry_active = 1'b1;
          s_d.bit_pos = s_q.bit_pos + 4'h1;
          if (s_q.bits_this_frame != pos_last)
            s_d.bits_this_frame = s_q.bits_this_frame + 4'h1;
          // Last bit of the entry, or last of the bits after a cut
          if (s_q.bit_pos == pos_last || tail_done)
          begin
            pop = 1'b1;
            s_d.bit_pos = '0;
            s_d.entry_active = 1'b0;
            s_d.resumed = 1'b0;
          end
        end
      end
    end
    // Select released: commit a write, settle a cut entry
    if (cs_rise)
    begin
      if (s_q.wr_pos != '0 || s_q.wr_done)
      begin
        s_d.cfg = s_q.wr_shift;
        s_d.cfg_stb = 1'b1;
        if (s_q.wr_done && s_q.wr_shift[reset_sel_pos] && s_q.wr_shift[7:5] == 3'h0)
        begin
          flush = 1'b1;
          s_d.bit_pos = '0;
          s_d.entry_active = 1'b0;
          s_d.resumed = 1'b0;
          if (!s_q.wr_shift[reset_scope_pos])
            s_d.cfg = config_reset_value;
          s_d.fault = 1'b0;
        end
      end
      if (s_q.entry_active && !flush)
      begin
        if (second_cut)
        begin
          // Second byte cut: drop rest of entry, later entries stay
          pop = 1'b1;
          s_d.bit_pos = '0;
          s_d.entry_active = 1'b0;
          s_d.resumed = 1'b0;
        end
        else if (first_cut)
          s_d.resumed = 1'b1;
      end
    end
  end
  // Temperature codes carry 3 fraction bits (0.125 degree step) in the same 12-bit field
  logic [entry_bits-1:0] fifo_in;
  assign fifo_in = result_is_temp ? entry_word : entry_word;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.cs_sync <= 2'h3;
      s_q.cs_prev <= 1'b1;
      s_q.sclk_prev <= 1'b0;
      s_q.cnv_sync <= 2'h3;
      s_q.cnv_prev <= 1'b1;
      s_q.eoc_n <= 1'b1;
      s_q.cfg <= config_reset_value;
    end
    else
      s_q <= s_d;
  end
  adc_result_fifo #(
    .width(entry_bits),
    .depth(queue_depth)
  ) u_queue (
    .clk(clk),
    .reset(reset),
    .flush(flush),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(fifo_in),
    .out_valid(q_valid),
    .out_ready(pop),
    .out_data(q_data)
  );
  assign dout = s_q.dout;
  assign dout_oe_n = s_q.cs_sync[1];
  assign eoc_n = s_q.eoc_n;
  assign config_value = s_q.cfg;
  assign config_strobe = s_q.cfg_stb;
  assign queue_fault = s_q.fault;
endmodule
`default_nettype wire

// ### adc_fifo_pkg.sv
// Package: constants for the ADC result queue serial readout block
package adc_fifo_pkg;
  localparam int unsigned entry_bits = 16;
  localparam int unsigned byte_bits = 8;
  localparam int unsigned result_bits = 12;
  localparam int unsigned reg_bits = 8;
  localparam int unsigned queue_depth = 8;
  localparam logic [2:0] reset_sel_pos = 3'h4;
  localparam logic [2:0] reset_scope_pos = 3'h3;
  localparam logic [7:0] config_reset_value = 8'h00;
  localparam logic [11:0] code_full_scale = 12'hfff;
  localparam int unsigned temp_frac_bits = 3;
  localparam logic [3:0] pos_last = 4'hf;
  localparam logic [3:0] pos_first_byte_end = 4'h7;
  localparam logic [2:0] wpos_last = 3'h7;
endpackage

// ### adc_result_fifo.sv
// Result queue: parameterised FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module adc_result_fifo #(
  parameter int unsigned width = 16,
  parameter int unsigned depth = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Flush
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int unsigned aw = $clog2(depth);
  typedef struct packed {
    logic [depth-1:0][width-1:0] mem;
    logic [aw-1:0] wr;
    logic [aw-1:0] rd;
    logic [aw:0] count;
  } fifo_state_t;
  fifo_state_t s_q;
  fifo_state_t s_d;
  logic push;
  logic pop;
  assign in_ready = (s_q.count != (aw+1)'(depth)) || pop;
  assign out_valid = s_q.count != '0;
  assign out_data = s_q.mem[s_q.rd];
  assign pop = out_valid && out_ready;
  assign push = in_valid && in_ready;
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == aw'(depth - 1)) ? '0 : s_q.wr + aw'(1);
    end
    if (pop)
      s_d.rd = (s_q.rd == aw'(depth - 1)) ? '0 : s_q.rd + aw'(1);
    s_d.count = s_q.count + (aw+1)'(push) - (aw+1)'(pop);
    if (flush)
    begin
      s_d.wr = '0;
      s_d.rd = '0;
      s_d.count = '0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule
`default_nettype wire

// ### adc_fifo_checker.sv
// Checker for select, flag and strobe timing at the block's pins
`timescale 1ns/100ps
`default_nettype none
module adc_fifo_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic convert_trigger_n,
  input wire logic scan_done,
  input wire logic eoc_n,
  input wire logic config_strobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_oe_off: assert property (cs_n [*5] |-> dout_oe_n)
    else $error("oe low");
  chk_oe_on: assert property (!cs_n [*5] |-> !dout_oe_n)
    else $error("oe high");
  chk_eoc_set: assert property (scan_done |-> ##[1:2] !eoc_n)
    else $error("eoc set");
  chk_eoc_hold: assert property ((!eoc_n && cs_n && convert_trigger_n) [*6] |=> !eoc_n)
    else $error("eoc hold");
  chk_eoc_trig: assert property ($fell(convert_trigger_n) |-> ##[2:6] eoc_n)
    else $error("eoc trig");
  chk_eoc_sel: assert property ($fell(cs_n) |-> ##[2:6] eoc_n)
    else $error("eoc sel");
  chk_strb_one: assert property (config_strobe |=> !config_strobe)
    else $error("strobe");
  chk_strb_desel: assert property (config_strobe |-> cs_n && $past(cs_n, 3))
    else $error("strobe sel");
  chk_dout_hold: assert property ((!cs_n && $stable(sclk) && $stable(cs_n)) [*6]
    |-> $stable(dout)) else $error("dout");
endmodule
`default_nettype wire

// ### adc_host_model.sv
// Host serial controller model
`timescale 1ns/100ps
`default_nettype none
module adc_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic eoc_n,
  // Received frame
  output logic [31:0] rx,
  output logic rx_stb,
  output logic late
);
  initial {cs_n, sclk, din, rx_stb, late, rx} = {5'h10, 32'h0};
  task automatic xfer(input int n, input logic [7:0] w, input bit obey);
    int i;
    i = 0;
    while (obey && eoc_n !== 1'b0 && i < 200)
    begin
      @(negedge clk);
      i++;
    end
    late = (i >= 200);
    rx = 32'h0;
    cs_n = 1'b0;
    repeat (6) @(negedge clk);
    for (i = 0; i < n; i++)
    begin
      din = (i < 8) ? w[7 - i] : 1'b0;
      repeat (5) @(negedge clk);
      sclk = 1'b1;
      rx = {rx[30:0], dout};
      repeat (5) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    din = ~din;
    rx_stb = 1'b1;
    @(negedge clk);
    rx_stb = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Testbench: queue fill, partial reads and writes, reset commands
`timescale 1ns/100ps
`default_nettype none
module tb;
  import adc_fifo_pkg::*;
  logic clk, reset, convert_trigger_n, scan_done, result_valid, result_is_temp;
  logic [11:0] result_code, d;
  logic [11:0] c [8];
  wire logic cs_n, sclk, din, dout, dout_oe_n, result_ready, eoc_n, config_strobe;
  wire logic queue_fault, rx_stb, late;
  wire logic [7:0] config_value;
  wire logic [31:0] rx;
  logic [31:0] exp_q [$];
  int failures, samples_checked, k;
  adc_fifo_partial_access adc_fifo_partial_access_i (.clk(clk), .reset(reset),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .convert_trigger_n(convert_trigger_n), .scan_done(scan_done),
    .result_valid(result_valid), .result_ready(result_ready), .result_code(result_code),
    .result_is_temp(result_is_temp), .eoc_n(eoc_n), .config_value(config_value),
    .config_strobe(config_strobe), .queue_fault(queue_fault));
  adc_host_model adc_host_model_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .eoc_n(eoc_n), .rx(rx), .rx_stb(rx_stb), .late(late));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic push(input logic [11:0] v);
    check("ready", result_ready, 1'b1);
    result_code = v;
    result_is_temp = 1'($urandom);
    result_valid = 1'b1;
    @(negedge clk);
    result_valid = 1'b0;
  endtask
  task automatic go(input int n, input logic [7:0] w, input bit chk, input logic [31:0] e);
    scan_done = 1'b1;
    @(negedge clk);
    scan_done = 1'b0;
    repeat (2) @(negedge clk);
    check("eoc", eoc_n, 1'b0);
    if (chk)
      exp_q.push_back(e);
    adc_host_model_i.xfer(n, w, 1'b1);
    repeat (10) @(negedge clk);
    $display("frame of %0d bits done", n);
  endtask
  always @(posedge rx_stb)
  begin
    check("late", late, 1'b0);
    if (exp_q.size() > 0)
      check("frame", rx, exp_q.pop_front());
  end
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {reset, convert_trigger_n, scan_done, result_valid, result_is_temp} = 5'h18;
    result_code = 12'h000;
    failures = 0;
    samples_checked = 0;
    void'($urandom(70));
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    for (k = 0; k < 8; k++)
    begin
      c[k] = 12'($urandom);
      push(c[k]);
    end
    check("full", result_ready, 1'b0);
    go(16, 8'h00, 1, {4'h0, c[0]});
    go(5, 8'h00, 1, {4'h0, c[1][11]});
    go(24, 8'h00, 1, {c[1][10:3], 4'h0, c[2]});
    go(12, 8'h00, 1, {4'h0, c[3][11:4]});
    go(16, 8'h00, 1, {4'h0, c[4]});
    go(8, 8'h18, 1, {4'h0, c[5][11:8]});
    d = 12'($urandom);
    push(d);
    go(8, 8'h00, 1, {4'h0, d[11:8]});
    go(8, 8'h00, 1, {24'h0, d[7:0]});
    go(8, 8'ha5, 0, 32'h0);
    check("config", config_value, 8'ha5);
    go(3, 8'h40, 0, 32'h0);
    check("config", config_value, 8'h45);
    check("fault", queue_fault, 1'b0);
    adc_host_model_i.xfer(0, 8'h00, 1'b0);
    repeat (10) @(negedge clk);
    check("fault", queue_fault, 1'b1);
    go(8, 8'h10, 0, 32'h0);
    check("config", config_value, config_reset_value);
    check("fault", queue_fault, 1'b0);
    scan_done = 1'b1;
    @(negedge clk);
    scan_done = 1'b0;
    repeat (10) @(negedge clk);
    check("eoc", eoc_n, 1'b0);
    convert_trigger_n = 1'b0;
    @(negedge clk);
    convert_trigger_n = 1'b1;
    repeat (6) @(negedge clk);
    check("eoc", eoc_n, 1'b1);
    print_verdict();
  end
endmodule
bind adc_fifo_partial_access adc_fifo_checker adc_fifo_checker_i (.clk(clk), .reset(reset),
  .cs_n(cs_n), .sclk(sclk), .dout(dout), .dout_oe_n(dout_oe_n), .scan_done(scan_done),
  .convert_trigger_n(convert_trigger_n), .eoc_n(eoc_n), .config_strobe(config_strobe));
`default_nettype wire
